/* common/dcr_consts.svh */
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH

// byte addresses of the control word, first holds bits 31:24
`define DCR_ADDR_FIRST 8'h1D
`define DCR_ADDR_LAST 8'h20

// reset value: vco high gain and pll bypass set, all else clear
`define DCR_RESET 32'h0060_0000

// field positions
`define DCR_BIT_COMP_PD 28
`define DCR_BIT_HALT 27
`define DCR_BIT_QDAC_PD 26
`define DCR_BIT_DAC_PD 25
`define DCR_BIT_DIG_PD 24
`define DCR_BIT_VCO_GAIN 22
`define DCR_BIT_PLL_BYPASS 21
`define DCR_MULT_HI 20
`define DCR_MULT_LO 16
`define DCR_BIT_CLR_ACC1 15
`define DCR_BIT_CLR_ACC 14
`define DCR_BIT_TRIANGLE 13
`define DCR_BIT_QDAC_SRC 12
`define DCR_MODE_HI 11
`define DCR_MODE_LO 9
`define DCR_BIT_INT_UPD 8
`define DCR_BIT_ISINC_BYP 6
`define DCR_BIT_OSK_EN 5
`define DCR_BIT_OSK_INT 4
`define DCR_BIT_LSB_FIRST 1
`define DCR_BIT_SDO_EN 0

`endif

/* common/dcr_pkg.sv */
package dcr_pkg;

    typedef enum logic [2:0]
    {
        DCR_MODE_SINGLE = 3'h0,
        DCR_MODE_FSK = 3'h1,
        DCR_MODE_RAMP_FSK = 3'h2,
        DCR_MODE_CHIRP = 3'h3,
        DCR_MODE_BPSK = 3'h4
    } dcr_mode_t;

    // decoded control outputs toward datapath and analog section
    typedef struct packed
    {
        logic comp_pd;
        logic q_dac_pd;
        logic iq_dac_pd;
        logic dig_clk_stop;
        logic vco_high_gain;
        logic pll_bypass;
        logic [4:0] pll_mult;
        logic acc_hold;
        logic sweep_triangle;
        logic qdac_from_reg;
        logic [2:0] mode;
        logic int_update;
        logic isinc_bypass;
        logic osk_en;
        logic osk_internal;
        logic lsb_first;
        logic sdo_en;
    } dcr_dec_t;

    // serial byte access from the port controller
    typedef struct packed
    {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcr_wr_t;

endpackage

/* rtl/dcr_update_pin.sv */
`timescale 1ns/1ps
module dcr_update_pin
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // direction and internal source
    input wire logic int_mode_in,
    input wire logic int_pulse_in,
    // update pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    // one-cycle transfer request
    output logic upd_out
);
    logic pin_prev_reg;
    logic pin_prev_next;
    logic upd_next;
    logic pin_out_next;
    logic pin_oe_next;

    always_comb
    begin
        pin_prev_next = pin_in;
        pin_oe_next = int_mode_in;
        pin_out_next = int_mode_in & int_pulse_in;
        if (int_mode_in)
        begin
            upd_next = int_pulse_in;
        end
        else
        begin
            upd_next = pin_in & ~pin_prev_reg;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_prev_reg <= 1'b0;
            upd_out <= 1'b0;
            pin_out <= 1'b0;
            pin_oe_out <= 1'b0;
        end
        else
        begin
            pin_prev_reg <= pin_prev_next;
            upd_out <= upd_next;
            pin_out <= pin_out_next;
            pin_oe_out <= pin_oe_next;
        end
    end
endmodule

/* rtl/dcr_sdo_route.sv */
`timescale 1ns/1ps
module dcr_sdo_route
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // configuration and read data
    input wire logic sdo_en_in,
    input wire logic drive_in,
    input wire logic bit_in,
    // bidirectional data pin
    output logic sdio_out,
    output logic sdio_oe_out,
    // separate output pin
    output logic sdo_out,
    output logic sdo_oe_out
);
    logic sdio_out_next;
    logic sdio_oe_next;
    logic sdo_out_next;
    logic sdo_oe_next;

    always_comb
    begin
        sdio_out_next = bit_in;
        sdo_out_next = bit_in;
        sdio_oe_next = drive_in & ~sdo_en_in;
        sdo_oe_next = drive_in & sdo_en_in;
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sdio_out <= 1'b0;
            sdio_oe_out <= 1'b0;
            sdo_out <= 1'b0;
            sdo_oe_out <= 1'b0;
        end
        else
        begin
            sdio_out <= sdio_out_next;
            sdio_oe_out <= sdio_oe_next;
            sdo_out <= sdo_out_next;
            sdo_oe_out <= sdo_oe_next;
        end
    end
endmodule

/* rtl/dcr_control_register.sv */
// Operation
// - bit 1 set selects lsb first, resets zero
// - 32-bit word at bytes 1D..20, top unused
// - bit 28 powers down comparator
// - bit 27 halts from the update that transfers it until reset
// - bit 26 powers down quadrature dac
// - bit 25 powers down both dacs, reference
// - bit 24 stops digital clocks, pll runs
// - bit 22 vco gain, resets one
// - bit 21 bypasses pll, resets one
// - bits 20:16 set pll multiplier
// - bit 15 one-shot accumulator 1 clear
// - bit 14 holds both accumulators zero
// - bit 13 triangle sweep, ramped fsk
// - bit 12 feeds q dac from register
// - bits 11:9 select operating mode
// - bit 8 makes update pin output
// - bit 6 bypasses, stops inverse sinc filter
// - bit 5 enables output amplitude ramping
// - bit 4 selects internal keying factor
// - bit 0 enables separate data output
// - port configuration applies at each update
// - output disabled keeps data on bidirectional
`timescale 1ns/1ps
`include "dcr_consts.svh"
module dcr_control_register
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // byte writes from the serial port controller
    input wire dcr_pkg::dcr_wr_t wr_in,
    // byte reads
    input wire logic [7:0] rd_addr_in,
    output logic [7:0] rdata_out,
    // register update strobe pin and internal source
    input wire logic register_update_strobe_in,
    output logic register_update_strobe_out,
    output logic register_update_strobe_oe_out,
    input wire logic int_update_in,
    // serial read data routing
    input wire logic read_drive_in,
    input wire logic read_bit_in,
    output logic sdio_out,
    output logic sdio_oe_out,
    output logic serial_data_output_out,
    output logic serial_data_output_oe_out,
    // decoded control
    output dcr_pkg::dcr_dec_t dec_out,
    output logic acc1_clear_out,
    output logic halted_out
);
    import dcr_pkg::*;

    logic [31:0] buf_reg;
    logic [31:0] buf_next;
    logic [31:0] act_reg;
    logic [31:0] act_next;
    logic halted_next;
    logic acc1_clear_next;
    logic [7:0] rdata_next;
    dcr_dec_t dec_next;
    logic upd;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic wr_hit;
    logic rd_hit;

    // ------------------------------------------------------------
    // pin helpers
    // ------------------------------------------------------------
    dcr_update_pin u_upd
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .int_mode_in(act_reg[`DCR_BIT_INT_UPD]),
        .int_pulse_in(int_update_in),
        .pin_in(register_update_strobe_in),
        .pin_out(register_update_strobe_out),
        .pin_oe_out(register_update_strobe_oe_out),
        .upd_out(upd)
    );

    dcr_sdo_route u_sdo
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .sdo_en_in(act_reg[`DCR_BIT_SDO_EN]),
        .drive_in(read_drive_in),
        .bit_in(read_bit_in),
        .sdio_out(sdio_out),
        .sdio_oe_out(sdio_oe_out),
        .sdo_out(serial_data_output_out),
        .sdo_oe_out(serial_data_output_oe_out)
    );

    // ------------------------------------------------------------
    // buffer, active word and one-shot
    // ------------------------------------------------------------
    assign wr_idx = wr_in.addr - `DCR_ADDR_FIRST;
    assign rd_idx = rd_addr_in - `DCR_ADDR_FIRST;
    assign wr_hit = wr_in.wr_en && wr_in.addr >= `DCR_ADDR_FIRST
        && wr_in.addr <= `DCR_ADDR_LAST;
    assign rd_hit = rd_addr_in >= `DCR_ADDR_FIRST
        && rd_addr_in <= `DCR_ADDR_LAST;

    always_comb
    begin
        buf_next = buf_reg;
        act_next = act_reg;
        halted_next = halted_out;
        acc1_clear_next = 1'b0;
        // first byte address carries the top byte
        if (wr_hit && !halted_out)
        begin
            if (wr_idx == 8'h00)
            begin
                buf_next[31:24] = wr_in.wdata;
            end
            else if (wr_idx == 8'h01)
            begin
                buf_next[23:16] = wr_in.wdata;
            end
            else if (wr_idx == 8'h02)
            begin
                buf_next[15:8] = wr_in.wdata;
            end
            else
            begin
                buf_next[7:0] = wr_in.wdata;
            end
        end
        // transfer on update; port bits take effect only at the update, like the rest
        if (upd && !halted_out)
        begin
            act_next = buf_next;
            act_next[31:29] = 3'h0;
            if (buf_next[`DCR_BIT_CLR_ACC1])
            begin
                acc1_clear_next = 1'b1;
                act_next[`DCR_BIT_CLR_ACC1] = 1'b0;
                buf_next[`DCR_BIT_CLR_ACC1] = 1'b0;
            end
            halted_next = buf_next[`DCR_BIT_HALT];
        end
    end

    // ------------------------------------------------------------
    // decode and readback
    // ------------------------------------------------------------
    always_comb
    begin
        dec_next.comp_pd = act_next[`DCR_BIT_COMP_PD];
        dec_next.q_dac_pd = act_next[`DCR_BIT_QDAC_PD]
            | act_next[`DCR_BIT_DAC_PD];
        dec_next.iq_dac_pd = act_next[`DCR_BIT_DAC_PD];
        dec_next.dig_clk_stop = act_next[`DCR_BIT_DIG_PD];
        dec_next.vco_high_gain = act_next[`DCR_BIT_VCO_GAIN];
        dec_next.pll_bypass = act_next[`DCR_BIT_PLL_BYPASS];
        dec_next.pll_mult = act_next[`DCR_MULT_HI:`DCR_MULT_LO];
        dec_next.acc_hold = act_next[`DCR_BIT_CLR_ACC];
        dec_next.sweep_triangle = act_next[`DCR_BIT_TRIANGLE];
        dec_next.qdac_from_reg = act_next[`DCR_BIT_QDAC_SRC];
        dec_next.mode = act_next[`DCR_MODE_HI:`DCR_MODE_LO];
        dec_next.int_update = act_next[`DCR_BIT_INT_UPD];
        dec_next.isinc_bypass = act_next[`DCR_BIT_ISINC_BYP];
        dec_next.osk_en = act_next[`DCR_BIT_OSK_EN];
        dec_next.osk_internal = act_next[`DCR_BIT_OSK_INT];
        dec_next.lsb_first = act_next[`DCR_BIT_LSB_FIRST];
        dec_next.sdo_en = act_next[`DCR_BIT_SDO_EN];
        rdata_next = 8'h00;
        if (rd_hit)
        begin
            if (rd_idx == 8'h00)
            begin
                rdata_next = act_reg[31:24];
            end
            else if (rd_idx == 8'h01)
            begin
                rdata_next = act_reg[23:16];
            end
            else if (rd_idx == 8'h02)
            begin
                rdata_next = act_reg[15:8];
            end
            else
            begin
                rdata_next = act_reg[7:0];
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            buf_reg <= `DCR_RESET;
            act_reg <= `DCR_RESET;
            halted_out <= 1'b0;
            acc1_clear_out <= 1'b0;
            rdata_out <= 8'h00;
            dec_out <= dcr_dec_t'(23'h06_0000);
        end
        else
        begin
            buf_reg <= buf_next;
            act_reg <= act_next;
            halted_out <= halted_next;
            acc1_clear_out <= acc1_clear_next;
            rdata_out <= rdata_next;
            dec_out <= dec_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    AST_LSB_FOLLOWS_BUF: assert property (
        (upd && !halted_out) |=> dec_out.lsb_first == $past(buf_next[1]))
        else $error("bit order not taken from update");
    AST_TOP_BYTE_WRITE: assert property (
        (wr_in.wr_en && wr_in.addr == 8'h1D && !halted_out)
        |=> buf_reg[31:24] == $past(wr_in.wdata))
        else $error("first byte address missed top byte");
    AST_HALT_FREEZES: assert property (
        halted_out |=> $stable(dec_out) && halted_out)
        else $error("control changed while halted");
    AST_QDAC_PD: assert property (
        dec_out.iq_dac_pd |-> dec_out.q_dac_pd)
        else $error("full dac power-down missed q dac");
    AST_ONE_SHOT: assert property (
        acc1_clear_out |=> !acc1_clear_out && !act_reg[15])
        else $error("accumulator clear not one-shot");
    AST_ONE_SHOT_CAUSE: assert property (
        (upd && !halted_out && buf_next[15]) |=> acc1_clear_out)
        else $error("accumulator clear not issued");
    AST_MODE_HOLD: assert property (
        !upd ##1 1'b1 |-> $stable(dec_out.mode))
        else $error("mode changed without update");
    AST_UPD_PIN_DIR: assert property (
        ##1 register_update_strobe_oe_out == $past(act_reg[8]))
        else $error("update pin direction wrong");
    AST_SDO_ROUTE: assert property (
        read_drive_in && !act_reg[0] |=> sdio_oe_out
        && !serial_data_output_oe_out)
        else $error("read data not on bidirectional pin");
    AST_SDO_ENABLED: assert property (
        read_drive_in && act_reg[0] |=> serial_data_output_oe_out
        && !sdio_oe_out)
        else $error("separate output not driven");
endmodule

/* tb/dcr_ctrl_model.sv */
`timescale 1ns/1ps
module dcr_ctrl_model
(
    // clock
    input wire logic mclk_in,
    // byte writes and update pin toward the device
    output dcr_pkg::dcr_wr_t wr_out,
    output logic pin_out
);
    import dcr_pkg::*;

    initial
    begin
        wr_out = '0;
        pin_out = 1'b0;
    end

    // ---------------------------------------------------------------
    // byte and word writes, back to back
    // ---------------------------------------------------------------
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_out <= '{1'b1, a, d};
        @(posedge mclk_in);
        wr_out.wr_en <= 1'b0;
        wr_out.wdata <= ~d;
    endtask

    task automatic write_word(input logic [31:0] w);
        logic [31:0] v;
        v = w & ~32'h0080_008c;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk_in);
            wr_out <= '{1'b1, 8'h1d + 8'(i), v[31 - 8 * i -: 8]};
        end
        @(posedge mclk_in);
        wr_out.wr_en <= 1'b0;
        wr_out.wdata <= ~v[7:0];
    endtask

    // ---------------------------------------------------------------
    // external update: one rising edge on the pin
    // ---------------------------------------------------------------
    task automatic pulse_update();
        @(posedge mclk_in);
        pin_out <= 1'b1;
        repeat (3) @(posedge mclk_in);
        pin_out <= 1'b0;
        @(posedge mclk_in);
    endtask
endmodule

/* tb/dcr_control_register_test.sv */
`timescale 1ns/1ps
module dcr_control_register_test;
    import dcr_pkg::*;

    logic mclk = 1'b0;
    logic rst;
    dcr_wr_t wr;
    logic pin_drv;
    logic pin_level;
    logic [7:0] rd_addr;
    logic [7:0] rdata;
    logic upd_out;
    logic upd_oe;
    logic int_upd;
    logic rd_drive;
    logic rd_bit;
    logic sdio, sdio_oe, sdo, sdo_oe, acc1_clr, halted;
    dcr_dec_t dec;
    logic [31:0] act = 32'h0060_0000;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int acc1_pulses = 0;

    always #4 mclk = ~mclk;
    // device drives the pin only while its enable is high
    assign pin_level = upd_oe ? upd_out : pin_drv;

    dcr_ctrl_model u_dcr_ctrl_model
    (
        .mclk_in(mclk),
        .wr_out(wr),
        .pin_out(pin_drv)
    );

    dcr_control_register u_dcr_control_register
    (
        .mclk_in(mclk),
        .rst_in(rst),
        .wr_in(wr),
        .rd_addr_in(rd_addr),
        .rdata_out(rdata),
        .register_update_strobe_in(pin_level),
        .register_update_strobe_out(upd_out),
        .register_update_strobe_oe_out(upd_oe),
        .int_update_in(int_upd),
        .read_drive_in(rd_drive),
        .read_bit_in(rd_bit),
        .sdio_out(sdio),
        .sdio_oe_out(sdio_oe),
        .serial_data_output_out(sdo),
        .serial_data_output_oe_out(sdo_oe),
        .dec_out(dec),
        .acc1_clear_out(acc1_clr),
        .halted_out(halted)
    );

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (acc1_clr === 1'b1)
            acc1_pulses <= acc1_pulses + 1;
        if (cycles == 3000)
        begin
            err_count++;
            end_of_test();
        end
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic dcr_dec_t exp_dec(input logic [31:0] w);
        dcr_dec_t d;
        d = '0;
        d.comp_pd = w[28];
        d.q_dac_pd = w[26] | w[25];
        d.iq_dac_pd = w[25];
        d.dig_clk_stop = w[24];
        d.vco_high_gain = w[22];
        d.pll_bypass = w[21];
        d.pll_mult = w[20:16];
        d.acc_hold = w[14];
        d.sweep_triangle = w[13];
        d.qdac_from_reg = w[12];
        d.mode = w[11:9];
        d.int_update = w[8];
        d.isinc_bypass = w[6];
        d.osk_en = w[5];
        d.osk_internal = w[4];
        d.lsb_first = w[1];
        d.sdo_en = w[0];
        return d;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic upd();
        u_dcr_ctrl_model.pulse_update();
        #1;
    endtask

    task automatic rd_word(output logic [31:0] w);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            rd_addr <= 8'h1d + 8'(i);
            tick(1);
            w[31 - 8 * i -: 8] = rdata;
        end
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        check(32'(dec), 32'(exp_dec(32'h0060_0000)));
        rd_word(r);
        check(r, 32'h0060_0000);
        @(posedge mclk);
        rd_addr <= 8'h21;
        tick(1);
        check(rdata, 8'h00);
        check({upd_oe, sdio_oe, sdo_oe, halted, acc1_clr}, 32'h0);
        $display("reset values done");
    endtask

    task automatic t_fields();
        logic [31:0] w;
        logic [31:0] r;
        for (int m = 0; m < 5; m++)
        begin
            w = m[0] ? 32'h0224_0020 : 32'hf554_5050;
            w = w | (32'(m) << 9);
            if (m == 2)
                w = w | 32'h0000_2000;
            u_dcr_ctrl_model.write_word(w);
            u_dcr_ctrl_model.write_byte(8'h1c, 8'hff);
            u_dcr_ctrl_model.write_byte(8'h21, 8'hff);
            tick(0);
            check(32'(dec), 32'(exp_dec(act)));
            upd();
            act = w & ~32'he080_008c;
            check(32'(dec), 32'(exp_dec(act)));
            rd_word(r);
            check(r, act);
        end
        $display("field decode done");
    endtask

    task automatic t_acc1();
        logic [31:0] r;
        int n;
        n = acc1_pulses;
        u_dcr_ctrl_model.write_word(32'h0000_8000);
        upd();
        tick(2);
        check(32'(acc1_pulses - n), 32'h1);
        act = 32'h0;
        rd_word(r);
        check(r, act);
        upd();
        tick(2);
        check(32'(acc1_pulses - n), 32'h1);
        $display("accumulator clear done");
    endtask

    task automatic t_int_upd();
        u_dcr_ctrl_model.write_word(32'h0000_0100);
        upd();
        check(upd_oe, 1'b1);
        u_dcr_ctrl_model.write_word(32'h0000_0700);
        @(posedge mclk);
        int_upd <= 1'b1;
        @(posedge mclk);
        int_upd <= 1'b0;
        tick(0);
        check(upd_out, 1'b1);
        tick(3);
        act = 32'h0000_0700;
        check(32'(dec), 32'(exp_dec(act)));
        u_dcr_ctrl_model.write_word(32'h0);
        @(posedge mclk);
        int_upd <= 1'b1;
        @(posedge mclk);
        int_upd <= 1'b0;
        tick(3);
        act = 32'h0;
        check(32'({upd_oe, dec}), 32'(exp_dec(act)));
        $display("internal update done");
    endtask

    task automatic t_serial();
        @(posedge mclk);
        rd_drive <= 1'b1;
        rd_bit <= 1'b1;
        tick(2);
        check({sdio_oe, sdio, sdo_oe}, 3'b110);
        u_dcr_ctrl_model.write_word(32'h0000_0003);
        upd();
        tick(1);
        act = 32'h3;
        check({sdio_oe, sdo_oe, sdo}, 3'b011);
        check(dec.lsb_first, 1'b1);
        @(posedge mclk);
        rd_bit <= 1'b0;
        tick(2);
        check({sdo_oe, sdo, sdio_oe}, 3'b100);
        @(posedge mclk);
        rd_drive <= 1'b0;
        tick(2);
        check({sdo_oe, sdio_oe}, 2'b00);
        $display("serial routing done");
    endtask

    task automatic t_halt();
        u_dcr_ctrl_model.write_word(32'h0800_0003);
        upd();
        check(halted, 1'b1);
        u_dcr_ctrl_model.write_word(32'h0000_0100);
        upd();
        check(32'({halted, dec}), 32'({1'b1, exp_dec(act)}));
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        tick(1);
        act = 32'h0060_0000;
        t_reset();
        $display("halt and reset done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        rst <= 1'b1;
        rd_addr <= 8'h00;
        int_upd <= 1'b0;
        rd_drive <= 1'b0;
        rd_bit <= 1'b0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        tick(1);
        t_reset();
        t_fields();
        t_acc1();
        t_int_upd();
        t_serial();
        t_halt();
        end_of_test();
    end
endmodule
